// file: hw/radio_sequencer_timing.sv
// Sequencer timing core with its global option registers on AHB-Lite
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "radio_seq_timing_regs.svh"

module radio_sequencer_timing (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  ce,
    input  wire radio_seq_pkg::ahb_in_t ahb_in,
    output      radio_seq_pkg::ahb_out_t ahb_out,
    input  wire logic                  trigger,
    input  wire logic [7:0]            first_init_delay,
    input  wire logic                  transfer_direction,
    input  wire logic                  pll_calibration_request,
    input  wire logic                  receive_trigger,
    input  wire logic                  done_trigger,
    input  wire logic                  tx_payload_ready_flag,
    input  wire logic [31:0]           payload_pointer,
    input  wire logic [31:0]           abs_time,
    input  wire logic                  radio_tx_ready,
    input  wire logic                  tx_last_bit,
    input  wire logic                  preamble_match,
    input  wire logic                  rx_frame_done,
    input  wire logic                  pll_lock_fail,
    input  wire logic                  pointer_error_flag,
    input  wire logic                  tables_ready_error_flag,
    output      radio_seq_pkg::seq_out_t seq_out
);
    import radio_seq_pkg::*;

    localparam logic [7:0] US_RELOAD  = 8'(`DELAY_UNIT_CYCLES - 1);
    localparam logic [4:0] PAD_RELOAD = 5'(`PAD_UNIT_CYCLES - 1);

    state_t s_ff;
    state_t nxt_s;

    logic        addr_ph;
    logic        us_tick;
    logic        pad_tick;
    logic        cnt_zero;
    logic [7:0]  sel_check;
    logic [23:0] rx_window;

    function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            `OFS_ACTIVE_CTRL:       r[`B_ACTIVE] = s.active;
            `OFS_DELAY_CHECKS:      r = s.delay_checks;
            `OFS_CONFIG_CAPTURE:    r = s.config_capture;
            `OFS_READY_RX_TIMEOUTS: r = s.ready_rx_timeouts;
            `OFS_OPTIONS_IRQ_EN:    r = s.options_irq_en;
            `OFS_EVENT_STATUS: begin
                r[`F_SEQ_ERR_IRQ_EN] = s.seq_err;
                r[`F_PRIMARY_IRQ_EN] = s.prim_flags;
            end
            `OFS_TIME_CAPTURE:      r = s.time_capture;
            `OFS_PAYLOAD_POINTER:   r = s.payload_ptr;
            default:                r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    always_comb begin
        nxt_s = s_ff;
        nxt_s.out.radio_request      = 1'b0;
        nxt_s.out.final_config_start = 1'b0;
        nxt_s.out.tx_block_start     = 1'b0;
        nxt_s.out.rx_block_start     = 1'b0;
        nxt_s.out.tx_end             = 1'b0;
        nxt_s.out.transfer_abort     = 1'b0;
        nxt_s.out.sequence_done      = 1'b0;

        // Shared prescalers; each phase load restarts them so delays are exact
        us_tick  = (s_ff.us_div == 8'h00);
        pad_tick = (s_ff.pad_div == 5'h00);
        nxt_s.us_div  = us_tick ? US_RELOAD : s_ff.us_div - 8'h01;
        nxt_s.pad_div = pad_tick ? PAD_RELOAD : s_ff.pad_div - 5'h01;
        cnt_zero = (s_ff.cnt == 24'h00_0000);

        unique case ({s_ff.dir_tx, s_ff.cal_req})
            2'b11:   sel_check = s_ff.snap_checks[`F_TX_CAL_CHECK];
            2'b10:   sel_check = s_ff.snap_checks[`F_TX_UNCAL_CHECK];
            2'b01:   sel_check = s_ff.snap_checks[`F_RX_CAL_CHECK];
            default: sel_check = s_ff.snap_checks[`F_RX_UNCAL_CHECK];
        endcase
        rx_window = {6'b00_0000, s_ff.snap_timeouts[`F_RX_WINDOW_MANT]}
                    << {s_ff.snap_timeouts[`F_RX_WINDOW_EXP], 1'b0};

        // Bus: address phase latches, write lands in the data phase
        addr_ph = ahb_in.hsel & ahb_in.hready & ahb_in.htrans[1];
        nxt_s.wr_pend = addr_ph & ahb_in.hwrite;
        nxt_s.wr_addr = ahb_in.haddr[7:0];
        nxt_s.bus.hreadyout = 1'b1;
        nxt_s.bus.hresp     = 1'b0;
        nxt_s.bus.hrdata    = (addr_ph & ~ahb_in.hwrite) ?
                              read_mux(s_ff, ahb_in.haddr[7:0]) : 32'h0000_0000;
        if (s_ff.wr_pend) begin
            unique case (s_ff.wr_addr)
                `OFS_ACTIVE_CTRL:       nxt_s.active = ahb_in.hwdata[`B_ACTIVE];
                `OFS_DELAY_CHECKS:
                    nxt_s.delay_checks = ahb_in.hwdata & `WMASK_DELAY_CHECKS;
                `OFS_CONFIG_CAPTURE:
                    nxt_s.config_capture = ahb_in.hwdata & `WMASK_CONFIG_CAPTURE;
                `OFS_READY_RX_TIMEOUTS:
                    nxt_s.ready_rx_timeouts = ahb_in.hwdata & `WMASK_READY_RX;
                `OFS_OPTIONS_IRQ_EN:
                    nxt_s.options_irq_en = ahb_in.hwdata & `WMASK_OPTIONS;
                `OFS_EVENT_STATUS: begin
                    nxt_s.seq_err    = s_ff.seq_err & ~ahb_in.hwdata[`F_SEQ_ERR_IRQ_EN];
                    nxt_s.prim_flags = s_ff.prim_flags & ~ahb_in.hwdata[`F_PRIMARY_IRQ_EN];
                end
                default: ;
            endcase
        end

        // Events below are applied after the clears, so a set wins
        if (pointer_error_flag) nxt_s.prim_flags[0] = 1'b1;
        if (tables_ready_error_flag) nxt_s.prim_flags[1] = 1'b1;
        if (trigger && s_ff.st != ST_IDLE) nxt_s.seq_err[0] = 1'b1;

        unique case (s_ff.st)
            ST_IDLE: begin
                if (trigger) begin
                    if (!s_ff.active) begin
                        nxt_s.prim_flags[3]      = 1'b1;
                        nxt_s.out.sequence_done  = 1'b1;
                    end else begin
                        // Fields are frozen here so firmware edits do not race us
                        nxt_s.snap_checks     = s_ff.delay_checks;
                        nxt_s.snap_config     = s_ff.config_capture;
                        nxt_s.snap_timeouts   = s_ff.ready_rx_timeouts;
                        nxt_s.snap_skip       = s_ff.options_irq_en[`B_PLL_FAIL_SKIP];
                        nxt_s.snap_auto_clear = s_ff.options_irq_en[`B_ACTIVE_AUTO_CLEAR];
                        nxt_s.dir_tx          = transfer_direction;
                        nxt_s.cal_req         = pll_calibration_request;
                        nxt_s.capture_trig    = receive_trigger | done_trigger;
                        nxt_s.trig_time       = abs_time;
                        nxt_s.cnt             = {16'h0000, first_init_delay};
                        nxt_s.us_div          = US_RELOAD;
                        nxt_s.st              = ST_INIT;
                    end
                end
            end
            ST_INIT: begin
                if (cnt_zero) begin
                    if (!s_ff.snap_config[`B_CAPTURE_SELECT]) begin
                        nxt_s.time_capture = abs_time;
                    end
                    nxt_s.out.radio_request = 1'b1;
                    nxt_s.out.request_is_tx = s_ff.dir_tx;
                    nxt_s.cnt      = {16'h0000, sel_check};
                    nxt_s.us_div   = US_RELOAD;
                    nxt_s.cfg_done = 1'b0;
                    nxt_s.dr_done  = 1'b0;
                    nxt_s.st       = ST_CHECK;
                end else if (us_tick) begin
                    nxt_s.cnt = s_ff.cnt - 24'h00_0001;
                end
            end
            ST_CHECK: begin
                // Remaining count at or below a margin means relative time reached delay-margin
                if (!s_ff.cfg_done &&
                    s_ff.cnt <= {16'h0000, s_ff.snap_config[`F_FINAL_CONFIG_MARGIN]}) begin
                    nxt_s.out.final_config_start = 1'b1;
                    nxt_s.cfg_done = 1'b1;
                end
                if (!s_ff.dr_done &&
                    s_ff.cnt <= {16'h0000, s_ff.snap_config[`F_DATA_READY_MARGIN]}) begin
                    nxt_s.payload_ptr   = payload_pointer;
                    nxt_s.payload_ready = tx_payload_ready_flag;
                    nxt_s.dr_done       = 1'b1;
                    if (s_ff.dir_tx && !tx_payload_ready_flag) begin
                        nxt_s.prim_flags[2] = 1'b1;
                        nxt_s.seq_err[4]    = 1'b1;
                    end
                end
                if (cnt_zero) begin
                    if (s_ff.snap_config[`B_CAPTURE_SELECT] &&
                        s_ff.snap_config[`B_CAPTURE_REQUEST]) begin
                        nxt_s.time_capture = abs_time;
                    end
                    nxt_s.us_div = US_RELOAD;
                    if (s_ff.dir_tx) begin
                        nxt_s.out.tx_block_start = 1'b1;
                        nxt_s.cnt = {16'h0000, s_ff.snap_timeouts[`F_TX_READY_TIMEOUT]};
                        nxt_s.st  = ST_TX_READY;
                    end else begin
                        nxt_s.out.rx_block_start = 1'b1;
                        nxt_s.cnt = rx_window;
                        nxt_s.st  = ST_RX_WINDOW;
                    end
                end else if (us_tick) begin
                    nxt_s.cnt = s_ff.cnt - 24'h00_0001;
                end
            end
            ST_TX_READY: begin
                if (radio_tx_ready) begin
                    nxt_s.cnt     = {16'h0000, s_ff.snap_config[`F_TX_START_PADDING]};
                    nxt_s.pad_div = PAD_RELOAD;
                    nxt_s.st      = ST_TX_PAD;
                end else if (cnt_zero) begin
                    // A zero field never expires: the wait is unbounded by design
                    if (s_ff.snap_timeouts[`F_TX_READY_TIMEOUT] != 8'h00) begin
                        nxt_s.seq_err[1] = 1'b1;
                        nxt_s.st         = ST_WRITEBACK;
                    end
                end else if (us_tick) begin
                    nxt_s.cnt = s_ff.cnt - 24'h00_0001;
                end
            end
            ST_TX_PAD: begin
                if (cnt_zero) begin
                    nxt_s.out.modulator_enable = 1'b1;
                    nxt_s.st = ST_TX_SEND;
                end else if (pad_tick) begin
                    nxt_s.cnt = s_ff.cnt - 24'h00_0001;
                end
            end
            ST_TX_SEND: begin
                if (tx_last_bit) begin
                    nxt_s.out.modulator_enable = 1'b0;
                    nxt_s.cnt     = {18'h0_0000, s_ff.snap_config[`F_TX_END_PADDING]};
                    nxt_s.pad_div = PAD_RELOAD;
                    nxt_s.st      = ST_TX_END;
                end
            end
            ST_TX_END: begin
                if (cnt_zero) begin
                    nxt_s.out.tx_end = 1'b1;
                    nxt_s.st = ST_WRITEBACK;
                end else if (pad_tick) begin
                    nxt_s.cnt = s_ff.cnt - 24'h00_0001;
                end
            end
            ST_RX_WINDOW: begin
                if (preamble_match) begin
                    nxt_s.st = ST_RX_FRAME;
                end else if (cnt_zero) begin
                    nxt_s.seq_err[2] = 1'b1;
                    nxt_s.st         = ST_WRITEBACK;
                end else if (us_tick) begin
                    nxt_s.cnt = s_ff.cnt - 24'h00_0001;
                end
            end
            ST_RX_FRAME: begin
                // Window no longer applies once a frame has been detected
                if (rx_frame_done) nxt_s.st = ST_WRITEBACK;
            end
            ST_WRITEBACK: begin
                if (s_ff.snap_auto_clear) nxt_s.active = 1'b0;
                if (s_ff.capture_trig) nxt_s.time_capture = s_ff.trig_time;
                nxt_s.out.sequence_done = 1'b1;
                nxt_s.st = ST_IDLE;
            end
            default: nxt_s.st = ST_IDLE;
        endcase

        // Lock failure during any transfer phase ends the sequence early
        if (s_ff.snap_skip && pll_lock_fail &&
            (s_ff.st == ST_TX_READY || s_ff.st == ST_TX_PAD || s_ff.st == ST_TX_SEND ||
             s_ff.st == ST_TX_END || s_ff.st == ST_RX_WINDOW || s_ff.st == ST_RX_FRAME)) begin
            nxt_s.out.modulator_enable = 1'b0;
            nxt_s.out.transfer_abort   = 1'b1;
            nxt_s.seq_err[3]           = 1'b1;
            nxt_s.st                   = ST_WRITEBACK;
        end

        nxt_s.out.debug_irq_line =
            |(nxt_s.seq_err & nxt_s.options_irq_en[`F_SEQ_ERR_IRQ_EN]);
        nxt_s.out.primary_irq_line =
            |(nxt_s.prim_flags & nxt_s.options_irq_en[`F_PRIMARY_IRQ_EN]);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff               <= '0;
            s_ff.bus.hreadyout <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign ahb_out = s_ff.bus;
    assign seq_out = s_ff.out;

endmodule // radio_sequencer_timing

// file: hw/radio_seq_timing_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RADIO_SEQ_TIMING_REGS_SVH
`define RADIO_SEQ_TIMING_REGS_SVH

// Byte offsets on the register bus
`define OFS_ACTIVE_CTRL        8'h04
`define OFS_DELAY_CHECKS       8'h08
`define OFS_CONFIG_CAPTURE     8'h0C
`define OFS_READY_RX_TIMEOUTS  8'h10
`define OFS_OPTIONS_IRQ_EN     8'h14
`define OFS_EVENT_STATUS       8'h18
`define OFS_TIME_CAPTURE       8'h1C
`define OFS_PAYLOAD_POINTER    8'h20

// Reset values
`define RST_DELAY_CHECKS       32'h0000_0000
`define RST_CONFIG_CAPTURE     32'h0000_0000
`define RST_READY_RX_TIMEOUTS  32'h0000_0000
`define RST_OPTIONS_IRQ_EN     32'h0000_0000

// Writable bits; the rest are reserved and read as zero
`define WMASK_DELAY_CHECKS     32'hFFFF_FFFF
`define WMASK_CONFIG_CAPTURE   32'hFFFF_FFFF
`define WMASK_READY_RX         32'h0FFF_FFFF
`define WMASK_OPTIONS          32'h00F0_1F05

// Field positions
`define F_TX_CAL_CHECK         7:0
`define F_TX_UNCAL_CHECK       15:8
`define F_RX_CAL_CHECK         23:16
`define F_RX_UNCAL_CHECK       31:24
`define F_FINAL_CONFIG_MARGIN  7:0
`define F_DATA_READY_MARGIN    15:8
`define F_TX_START_PADDING     23:16
`define F_TX_END_PADDING       29:24
`define B_CAPTURE_SELECT       30
`define B_CAPTURE_REQUEST      31
`define F_TX_READY_TIMEOUT     7:0
`define F_RX_WINDOW_MANT       25:8
`define F_RX_WINDOW_EXP        27:26
`define B_PLL_FAIL_SKIP        0
`define B_ACTIVE_AUTO_CLEAR    2
`define F_SEQ_ERR_IRQ_EN       12:8
`define F_PRIMARY_IRQ_EN       23:20
`define B_ACTIVE               7

// Timing
`define CLK_PERIOD_NS          5
`define DELAY_UNIT_NS          1000
`define PAD_UNIT_NS            125
`define DELAY_UNIT_CYCLES      (`DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define PAD_UNIT_CYCLES        (`PAD_UNIT_NS / `CLK_PERIOD_NS)

`endif

// file: hw/radio_seq_pkg.sv
// Types shared by the sequencer timing block
package radio_seq_pkg;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_INIT      = 4'h1,
        ST_CHECK     = 4'h3,
        ST_TX_READY  = 4'h2,
        ST_TX_PAD    = 4'h6,
        ST_TX_SEND   = 4'h7,
        ST_TX_END    = 4'h5,
        ST_WRITEBACK = 4'h4,
        ST_RX_WINDOW = 4'hB,
        ST_RX_FRAME  = 4'hA
    } seq_state_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_in_t;

    typedef struct packed {
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
    } ahb_out_t;

    typedef struct packed {
        logic radio_request;
        logic request_is_tx;
        logic final_config_start;
        logic tx_block_start;
        logic rx_block_start;
        logic modulator_enable;
        logic tx_end;
        logic transfer_abort;
        logic sequence_done;
        logic debug_irq_line;
        logic primary_irq_line;
    } seq_out_t;

    typedef struct packed {
        seq_state_t  st;
        ahb_out_t    bus;
        seq_out_t    out;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] delay_checks;
        logic [31:0] config_capture;
        logic [31:0] ready_rx_timeouts;
        logic [31:0] options_irq_en;
        logic        active;
        logic [4:0]  seq_err;
        logic [3:0]  prim_flags;
        logic [31:0] time_capture;
        logic [31:0] trig_time;
        logic [31:0] payload_ptr;
        logic        payload_ready;
        logic        dir_tx;
        logic        cal_req;
        logic        capture_trig;
        logic [31:0] snap_checks;
        logic [31:0] snap_config;
        logic [31:0] snap_timeouts;
        logic        snap_skip;
        logic        snap_auto_clear;
        logic [23:0] cnt;
        logic [7:0]  us_div;
        logic [4:0]  pad_div;
        logic        cfg_done;
        logic        dr_done;
    } state_t;

endpackage

// file: test/radio_sequencer_timing_chk.sv
// Concurrent checks on the sequencer timing block ports
`timescale 1ns/100ps
`include "radio_seq_timing_regs.svh"
module radio_sequencer_timing_chk
    import radio_seq_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     arst_n,
    input wire radio_seq_pkg::ahb_in_t   ahb_in,
    input wire radio_seq_pkg::ahb_out_t  ahb_out,
    input wire radio_seq_pkg::seq_out_t  seq_out,
    input wire logic                     radio_tx_ready,
    input wire logic                     tx_last_bit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    int         since_req;
    int         since_last;
    logic       cfg_seen;
    logic       rd_ph;
    logic [7:0] rd_adr;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_req <= 0;
            since_last <= 0;
            cfg_seen <= 1'b0;
            rd_ph <= 1'b0;
            rd_adr <= 8'h00;
        end else begin
            since_req <= seq_out.radio_request ? 0 : since_req + 1;
            since_last <= tx_last_bit ? 0 : since_last + 1;
            cfg_seen <= !seq_out.radio_request && (cfg_seen || seq_out.final_config_start);
            rd_ph <= ahb_in.hsel & ahb_in.hready & ahb_in.htrans[1] & ~ahb_in.hwrite;
            rd_adr <= ahb_in.haddr[7:0];
        end
    end
    sequence s_block_start;
        seq_out.tx_block_start || seq_out.rx_block_start;
    endsequence
    sequence s_done_soon;
        ##[1:3] seq_out.sequence_done;
    endsequence
    property p_block_dir;
        (seq_out.tx_block_start |-> seq_out.request_is_tx)
        and (seq_out.rx_block_start |-> !seq_out.request_is_tx);
    endproperty
    a_block_dir: assert property (p_block_dir) else $error("start pulse of wrong kind");
    property p_check_bound;
        s_block_start |-> since_req inside {[2:51400]};
    endproperty
    a_check_bound: assert property (p_check_bound) else $error("start pulse out of range");
    property p_cfg_first;
        s_block_start |-> cfg_seen || seq_out.final_config_start;
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("start before final config");
    property p_mod_ready;
        $rose(seq_out.modulator_enable) |-> $past(radio_tx_ready);
    endproperty
    a_mod_ready: assert property (p_mod_ready) else $error("modulator before tx ready");
    property p_end_pad;
        seq_out.tx_end |-> since_last inside {[1:1600]};
    endproperty
    a_end_pad: assert property (p_end_pad) else $error("tx end not after last bit");
    property p_done_after_end;
        seq_out.tx_end |-> s_done_soon;
    endproperty
    a_done_after_end: assert property (p_done_after_end) else $error("no done after tx end");
    property p_rsvd_zero;
        rd_ph && rd_adr == `OFS_READY_RX_TIMEOUTS |-> ahb_out.hrdata[31:28] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");
    property p_done_pulse;
        seq_out.sequence_done |=> !seq_out.sequence_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
endmodule // radio_sequencer_timing_chk

// file: test/radio_seq_partner.sv
// Behavioural radio state machine and modulator facing the sequencer
`timescale 1ns/100ps
module radio_seq_partner
    import radio_seq_pkg::*;
(
    input  wire logic                    clk,
    input  wire radio_seq_pkg::seq_out_t seq_out,
    input  wire logic [15:0]             ready_dly,
    input  wire logic                    rx_silent,
    output logic                         radio_tx_ready,
    output logic                         tx_last_bit,
    output logic                         preamble_match,
    output logic                         rx_frame_done
);
    int cnt = 0;
    int ph = 0;
    initial {radio_tx_ready, tx_last_bit, preamble_match, rx_frame_done} = 4'h0;
    // Slow ready delay is set by the bench to force a timeout
    always @(posedge clk) begin
        tx_last_bit <= 1'b0;
        preamble_match <= 1'b0;
        rx_frame_done <= 1'b0;
        cnt <= cnt + 1;
        case (ph)
            1: if (cnt == int'(ready_dly)) begin radio_tx_ready <= 1'b1; ph <= 2; end
            2: if (seq_out.modulator_enable) begin cnt <= 0; ph <= 3; end
            3: if (cnt == 40) begin tx_last_bit <= 1'b1; ph <= 0; end
            4: if (cnt == 30 && !rx_silent) begin preamble_match <= 1'b1; ph <= 5; end
            5: if (cnt == 50) begin rx_frame_done <= 1'b1; ph <= 0; end
            default: ph <= 0;
        endcase
        if (seq_out.tx_block_start) begin cnt <= 0; ph <= 1; end
        if (seq_out.rx_block_start) begin cnt <= 0; ph <= 4; end
        if (seq_out.tx_end | seq_out.sequence_done) radio_tx_ready <= 1'b0;
    end
endmodule // radio_seq_partner

// file: test/radio_sequencer_timing_bench.sv
// Self-checking bench for the sequencer timing block
`timescale 1ns/100ps
`include "radio_seq_timing_regs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module radio_sequencer_timing_bench;
    import radio_seq_pkg::*;
    logic        clk = 0, arst_n = 0, trigger = 0, dir = 0, cal = 0, rx_silent = 0;
    logic        rtrg = 0, dtrg = 0, pay_rdy = 1;
    logic [31:0] pay_ptr = 32'h0000_0000, rdv, w;
    logic [7:0]  ofs [4] = '{`OFS_DELAY_CHECKS, `OFS_CONFIG_CAPTURE, `OFS_READY_RX_TIMEOUTS,
                             `OFS_OPTIONS_IRQ_EN};
    logic [31:0] msk [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0FFF_FFFF, 32'h00F0_1F05};
    ahb_in_t     m = '0;
    ahb_out_t    ahb_out;
    seq_out_t    seq_out;
    logic        radio_tx_ready, tx_last_bit, preamble_match, rx_frame_done;
    int          err_count = 0, tests_run = 0, cyc = 0, ready_dly = 5, n_req = 0, d, lo;
    int          t_req, t_bs, t_rdy, t_mod, t_last, t_end, t_dn;
    radio_sequencer_timing radio_sequencer_timing_inst (
        .clk(clk), .arst_n(arst_n), .ce(1'b1),
        .ahb_in({m[$bits(ahb_in_t)-1:1], ahb_out.hreadyout}), .ahb_out(ahb_out),
        .trigger(trigger), .first_init_delay(8'h01), .transfer_direction(dir),
        .pll_calibration_request(cal), .receive_trigger(rtrg), .done_trigger(dtrg),
        .tx_payload_ready_flag(pay_rdy), .payload_pointer(pay_ptr), .abs_time(32'(cyc)),
        .radio_tx_ready(radio_tx_ready), .tx_last_bit(tx_last_bit),
        .preamble_match(preamble_match), .rx_frame_done(rx_frame_done), .pll_lock_fail(1'b0),
        .pointer_error_flag(1'b0), .tables_ready_error_flag(1'b0), .seq_out(seq_out));
    radio_seq_partner radio_seq_partner_inst (
        .clk(clk), .seq_out(seq_out), .ready_dly(16'(ready_dly)), .rx_silent(rx_silent),
        .radio_tx_ready(radio_tx_ready), .tx_last_bit(tx_last_bit),
        .preamble_match(preamble_match), .rx_frame_done(rx_frame_done));
    initial forever #2.5 clk = ~clk;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (seq_out.radio_request) begin t_req <= cyc; n_req <= n_req + 1; end
        if (seq_out.tx_block_start | seq_out.rx_block_start) t_bs <= cyc;
        if ($rose(radio_tx_ready)) t_rdy <= cyc;
        if ($rose(seq_out.modulator_enable)) t_mod <= cyc;
        if (tx_last_bit) t_last <= cyc;
        if (seq_out.tx_end) t_end <= cyc;
        if (seq_out.sequence_done) t_dn <= cyc;
        if (cyc == 40000) begin err_count++; end_sim(); end
    end
    task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] dt);
        m.hsel <= 1'b1;
        m.haddr <= {24'h00_0000, a};
        m.htrans <= 2'h2;
        m.hwrite <= wr_n;
        m.hsize <= 3'h2;
        do @(posedge clk); while (!ahb_out.hreadyout);
        m.htrans <= 2'h0;
        m.hwdata <= dt;
        do @(posedge clk); while (!ahb_out.hreadyout);
        rdv = ahb_out.hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        bus(1'b1, a, dt);
    endtask
    // Pulse trigger, then wait up to 20000 cycles for the done pulse
    task automatic run(input logic dr, input logic cl);
        {t_req, t_bs, t_rdy, t_mod, t_last, t_end, t_dn, n_req} = '0;
        dir <= dr;
        cal <= cl;
        rtrg <= 1'($urandom());
        pay_ptr <= $urandom();
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
        for (int k = 0; k < 20000 && seq_out.sequence_done !== 1'b1; k++) @(posedge clk);
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(97));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            `CHK("reset value", 32'h0000_0000, rdv)
            w = $urandom();
            wr(ofs[i], w);
            bus(1'b0, ofs[i], 32'h0);
            `CHK("readback", w & msk[i], rdv)
        end
        wr(8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0000_0000, rdv)
        $display("register test done");
        wr(`OFS_OPTIONS_IRQ_EN, 32'h0080_0000);
        wr(`OFS_ACTIVE_CTRL, 32'h0000_0000);
        run(1'b1, 1'b0);
        `CHK("request while inactive", 0, n_req)
        bus(1'b0, `OFS_EVENT_STATUS, 32'h0);
        `CHK("inactive flag", 1'b1, rdv[23])
        `CHK("primary irq", 1'b1, seq_out.primary_irq_line)
        wr(`OFS_EVENT_STATUS, 32'h0080_0000);
        repeat (2) @(posedge clk);
        `CHK("primary irq clear", 1'b0, seq_out.primary_irq_line)
        $display("inactive test done");
        wr(`OFS_DELAY_CHECKS, 32'h0705_0301);
        wr(`OFS_CONFIG_CAPTURE, 32'h0304_0000);
        wr(`OFS_READY_RX_TIMEOUTS, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_OPTIONS_IRQ_EN, (i == 3) ? 32'h0000_0004 : 32'h0000_0000);
            wr(`OFS_ACTIVE_CTRL, 32'h0000_0080);
            ready_dly <= 3 + 40 * i;
            run(i < 2, i[0]);
            d = (32'h0705_0301 >> (8 * (2 * (i >= 2) + (i[0] ? 0 : 1)))) & 8'hFF;
            `CHK("check delay", 1'b1, (t_bs - t_req) inside {[d*200-5:d*200+205]})
            if (i < 2) begin
                `CHK("start padding", 1'b1, (t_mod - t_rdy) inside {[100:129]})
                `CHK("end padding", 1'b1, (t_end - t_last) inside {[75:104]})
            end
            bus(1'b0, `OFS_ACTIVE_CTRL, 32'h0);
            `CHK("active after run", (i == 3) ? 32'h0 : 32'h80, rdv)
        end
        $display("sequence test done");
        wr(`OFS_READY_RX_TIMEOUTS, 32'h0400_0102);
        wr(`OFS_OPTIONS_IRQ_EN, 32'h0000_0600);
        for (int j = 0; j < 2; j++) begin
            rx_silent <= 1'b1;
            ready_dly <= 3000;
            wr(`OFS_ACTIVE_CTRL, 32'h0000_0080);
            run(j[0], 1'b1);
            lo = (j ? 400 : 800) - 5;
            `CHK("timeout length", 1'b1, (t_dn - t_bs) inside {[lo:lo+230]})
            bus(1'b0, `OFS_EVENT_STATUS, 32'h0);
            `CHK("timeout flag", 1'b1, rdv[j ? 9 : 10])
            `CHK("debug irq", 1'b1, seq_out.debug_irq_line)
            wr(`OFS_EVENT_STATUS, 32'hFFFF_FFFF);
            repeat (2) @(posedge clk);
            `CHK("debug irq clear", 1'b0, seq_out.debug_irq_line)
        end
        $display("timeout test done");
        end_sim();
    end
endmodule // radio_sequencer_timing_bench
bind radio_sequencer_timing radio_sequencer_timing_chk radio_sequencer_timing_chk_inst (
    .clk(clk), .arst_n(arst_n), .ahb_in(ahb_in), .ahb_out(ahb_out), .seq_out(seq_out),
    .radio_tx_ready(radio_tx_ready), .tx_last_bit(tx_last_bit));
